// ### burner_sequence_jumper_decode.sv
// Purpose: Decode three clip jumpers into one of five burner run sequences.
// Assumes: Jumpers are synchronous levels; 1 means intact, 0 means clipped.
// Notes: Clipped state is latched per jumper, so selection never reverts.
`timescale 1ns/10ps
module burner_sequence_jumper_decode
  import burner_sequence_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input burner_sequence_pkg::jumper_set_type jumpers,
  output burner_sequence_pkg::sequence_type selected_sequence,
  output burner_sequence_pkg::sequence_traits_type sequence_traits,
  output logic lockout,
  output logic config_ready
);
  import burner_sequence_pkg::*;

  // Sticky jumper memory and its next value.
  jumper_set_type seen;
  jumper_set_type next_seen;

  // Loader state machine and its settle counter.
  loader_state_type state;
  loader_state_type next_state;
  logic [1:0] settle_count;
  logic [1:0] next_settle_count;

  // Decode of the merged jumper set.
  sequence_type decoded;
  sequence_traits_type decoded_traits;
  logic decoded_lockout;

  // Timing qualifiers of the loader.
  logic decode_window;
  logic settle_done;
  logic freeze_now;

  // The case reads the jumpers in the order first, second, third, so
  // each code matches a row of the jumper table read left to right.
  function automatic sequence_type decode_jumpers(input jumper_set_type j);
    case ({j.config_jumper_first, j.config_jumper_second,
           j.config_jumper_third})
      3'h7: decode_jumpers = seq_pilot_relight_variant;
      3'h4: decode_jumpers = seq_dsi_normal;
      3'h2: decode_jumpers = seq_dsi_high_low_stepfire;
      3'h1: decode_jumpers = seq_dsi_off_on_stepfire;
      3'h6: decode_jumpers = seq_main_valve_low_fire_variant;
      default: decode_jumpers = seq_lockout;
    endcase
  endfunction

  // four sequence traits
  // Lockout and the reset code leave every trait low, so a sequencer
  // that ignored the lockout flag still could not open a valve or spark.
  function automatic sequence_traits_type traits_of(input sequence_type s);
    sequence_traits_type t;
    t = '0;
    case (s)
      seq_pilot_relight_variant: begin
        t.pilot_enabled = 1'b1;
        t.pilot_relight_allowed = 1'b1;
      end
      seq_main_valve_low_fire_variant: begin
        t.pilot_enabled = 1'b1;
        t.main_valve_hold_low_fire = 1'b1;
      end
      // Every direct spark variant lights the main burner straight from
      // the spark, with no pilot stage in front of it.
      seq_dsi_normal: begin
        t.direct_spark = 1'b1;
      end
      seq_dsi_high_low_stepfire: begin
        t.direct_spark = 1'b1;
      end
      seq_dsi_off_on_stepfire: begin
        t.direct_spark = 1'b1;
      end
      default: begin
        t = '0;
      end
    endcase
    traits_of = t;
  endfunction

  // clipped is sticky
  // A clip is an AND into the remembered set: a bit can only fall, so a
  // cut jumper that touches its pads again is still read as clipped.
  assign next_seen = jumper_set_type'(seen & jumpers);

  // The decode reads the merged set rather than the raw pins, so the
  // edge that first sees a clip already reports the new sequence.
  assign decoded = decode_jumpers(next_seen);
  assign decoded_traits = traits_of(decoded);
  // lockout from decode
  // The flag comes from the same code, so flag and code cannot split.
  assign decoded_lockout = (decoded == seq_lockout);

  // decode window
  // Outputs follow the decode in every state except hold.
  assign decode_window = (state != st_hold);
  // The settle phase ends on the edge that sees the last count value.
  assign settle_done = (settle_count == settle_cycles);
  assign freeze_now = decode_window && (next_state == st_hold);
  // The count moves only while settling, so it rests once hold is
  // reached and cannot wrap round into a second settle.
  assign next_settle_count = (state == st_settle) ?
                             2'(settle_count + 2'h1) : settle_count;

  // Initiate takes one edge, settle runs until the count is done, and
  // hold lasts until the next reset. Settling over a few cycles lets a
  // bouncing clip be caught before use, at the price of a short delay
  // before the sequencer may start.
  always_comb begin
    next_state = state;
    case (state)
      st_initiate: begin
        next_state = st_settle;
      end
      st_settle: begin
        if (settle_done) begin
          next_state = st_hold;
        end
      end
      st_hold: begin
        next_state = st_hold;
      end
      default: begin
        next_state = st_initiate;
      end
    endcase
  end

  // sticky jumper memory
  // Only a power-up reset brings the memory back to all intact.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seen <= jumper_reset_value;
    end else begin
      seen <= next_seen;
    end
  end

  // The loader runs once per reset and then parks in hold for good.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= st_initiate;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      settle_count <= settle_count_reset;
    end else begin
      settle_count <= next_settle_count;
    end
  end

  // A clip made while running still latches in seen but never reaches
  // the outputs before the next reset, so the selection cannot revert.
  // decode during initiate and settle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      selected_sequence <= sequence_reset_value;
    end else if (decode_window) begin
      selected_sequence <= decoded;
    end
  end

  // Traits move on the same edge as the code, so the two never disagree.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sequence_traits <= traits_reset_value;
    end else if (decode_window) begin
      sequence_traits <= decoded_traits;
    end
  end

  // lockout output
  // Lockout is a flag of its own so the sequencer can trip without
  // decoding the sequence code first.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lockout <= 1'b0;
    end else if (decode_window) begin
      lockout <= decoded_lockout;
    end
  end

  // The ready flag rises on the edge of the last decode, so a reader
  // that waits for it always sees the frozen code.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      config_ready <= 1'b0;
    end else if (decode_window) begin
      config_ready <= freeze_now;
    end
  end

endmodule // burner_sequence_jumper_decode

// ### burner_sequence_pkg.sv
// Purpose: Shared types and constants for the burner sequence jumper decode.
// Assumes: Jumper inputs are static levels, high while the jumper is intact.
// Notes: Sequence codes other than seq_none are one-hot so the sequencer can test single bits.
package burner_sequence_pkg;

  localparam int jumper_count = 3;

  typedef enum logic [5:0] {
    seq_none = 6'h00,
    seq_pilot_relight_variant = 6'h01,
    seq_main_valve_low_fire_variant = 6'h02,
    seq_dsi_normal = 6'h04,
    seq_dsi_high_low_stepfire = 6'h08,
    seq_dsi_off_on_stepfire = 6'h10,
    seq_lockout = 6'h20
  } sequence_type;

  typedef enum logic [2:0] {
    st_initiate = 3'h1,
    st_settle = 3'h2,
    st_hold = 3'h4
  } loader_state_type;

  typedef struct packed {
    logic config_jumper_first;
    logic config_jumper_second;
    logic config_jumper_third;
  } jumper_set_type;

  typedef struct packed {
    logic pilot_enabled;
    logic pilot_relight_allowed;
    logic main_valve_hold_low_fire;
    logic direct_spark;
  } sequence_traits_type;

  localparam jumper_set_type jumper_reset_value = 3'h7;
  localparam logic [1:0] settle_cycles = 2'h2;
  localparam logic [1:0] settle_count_reset = 2'h0;
  localparam sequence_type sequence_reset_value = seq_none;
  localparam sequence_traits_type traits_reset_value = 4'h0;

endpackage

// ### burner_sequence_assertions.sv
// Purpose: Port checks for the jumper decode.
// Assumes: Outputs are registered; sequence codes are one-hot apart from seq_none.
// Notes: Bound to the design.
`timescale 1ns/10ps
module burner_sequence_assertions
  import burner_sequence_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire burner_sequence_pkg::jumper_set_type jumpers,
  input wire burner_sequence_pkg::sequence_type selected_sequence,
  input wire burner_sequence_pkg::sequence_traits_type sequence_traits,
  input wire logic lockout,
  input wire logic config_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_frozen_output: assert property (config_ready |=>
    $stable(selected_sequence) && config_ready) else $error("unfrozen");
  chk_ready_time: assert property ($fell(reset) |->
    !config_ready [*4] ##1 config_ready) else $error("ready late");
  chk_no_revert: assert property (selected_sequence != seq_none &&
    selected_sequence != seq_pilot_relight_variant |=>
    selected_sequence != seq_pilot_relight_variant) else $error("revert");
  chk_dsi_decode: assert property (!config_ready && jumpers == 3'h4
    |=> selected_sequence inside {seq_dsi_normal, seq_lockout})
    else $error("dsi decode");
  chk_relight_traits: assert property (selected_sequence ==
    seq_pilot_relight_variant |-> sequence_traits == 4'hC)
    else $error("relight traits");
  chk_lowfire_traits: assert property (selected_sequence ==
    seq_main_valve_low_fire_variant |-> sequence_traits == 4'hA)
    else $error("lowfire traits");
  chk_spark_traits: assert property (selected_sequence inside
    {seq_dsi_normal, seq_dsi_high_low_stepfire, seq_dsi_off_on_stepfire}
    |-> sequence_traits == 4'h1) else $error("spark traits");
  chk_lockout_flag: assert property (
    lockout == (selected_sequence == seq_lockout)) else $error("lockout");
endmodule // burner_sequence_assertions
bind burner_sequence_jumper_decode burner_sequence_assertions
  burner_sequence_assertions_i (.clock(clock), .reset(reset),
  .jumpers(jumpers), .selected_sequence(selected_sequence),
  .sequence_traits(sequence_traits), .lockout(lockout),
  .config_ready(config_ready));

// ### burner_sequence_jumper_decode_tb.sv
// Purpose: Self-checking bench for the jumper decode.
// Assumes: Jumpers change 1 ns after a rising edge.
// Notes: Random clips before freeze, noise after it.
`timescale 1ns/10ps
module burner_sequence_jumper_decode_tb;
  import burner_sequence_pkg::*;
  logic clock = 0, reset = 1, lockout, config_ready;
  jumper_set_type jumpers = 3'h7;
  sequence_type selected_sequence;
  sequence_traits_type sequence_traits;
  int err_total = 0, num_checks = 0;
  always #10 clock = ~clock;
  burner_sequence_jumper_decode burner_sequence_jumper_decode_i (
    .clock(clock), .reset(reset), .jumpers(jumpers),
    .selected_sequence(selected_sequence), .lockout(lockout),
    .sequence_traits(sequence_traits), .config_ready(config_ready));
  function automatic logic [5:0] decode(input logic [2:0] j);
    case (j)
      3'h7: return seq_pilot_relight_variant;
      3'h6: return seq_main_valve_low_fire_variant;
      3'h4: return seq_dsi_normal;
      3'h2: return seq_dsi_high_low_stepfire;
      3'h1: return seq_dsi_off_on_stepfire;
      default: return seq_lockout;
    endcase
  endfunction
  function automatic logic [3:0] traits(input logic [2:0] j);
    case (j)
      3'h7: return 4'hC;
      3'h6: return 4'hA;
      3'h4, 3'h2, 3'h1: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic start(input logic [2:0] j);
    @(posedge clock) #1 reset = 1;
    jumpers = j;
    repeat (20) @(posedge clock);
    #1 reset = 0;
  endtask
  task automatic settle(input int want);
    int n;
    n = 0;
    while (config_ready !== 1'b1 && n < 9) begin
      @(posedge clock) #1 n++;
    end
    check(6'(n), 6'(want));
  endtask
  initial begin
    logic [2:0] r, s;
    void'($urandom(32'h4383ec7b));
    for (int k = 0; k < 8; k++) begin
      start(k[2:0]);
      settle(4);
      check(selected_sequence, decode(k[2:0]));
      check(6'(sequence_traits), 6'(traits(k[2:0])));
      check(6'(lockout), 6'(decode(k[2:0]) == seq_lockout));
      repeat (12) begin
        @(posedge clock) #1 jumpers = 3'($urandom);
        check(selected_sequence, decode(k[2:0]));
        check(6'(sequence_traits), 6'(traits(k[2:0])));
      end
      $display("table test %0d done", k);
    end
    for (int i = 0; i < 10; i++) begin
      r = (i == 0) ? 3'h4 : 3'($urandom);
      s = (i == 0) ? 3'h7 : 3'($urandom);
      start(r);
      @(posedge clock) #1 jumpers = s;
      settle(3);
      check(selected_sequence, decode(r & s));
      check(6'(sequence_traits), 6'(traits(r & s)));
      $display("clip test %0d done", i);
    end
    end_sim;
  end
  initial begin
    #100000 err_total++;
    end_sim;
  end
endmodule // burner_sequence_jumper_decode_tb
